//--- common/tnb_pkg.sv
// package for the task nesting and busy control block
// shared by the control core, its checker, the pipeline model and the top bench
package tnb_pkg;
    // selector and task table sizes
    localparam int TNB_SEL_W = 16;
    localparam int TNB_IDX_W = 6;
    localparam int TNB_SEL_IDX_LSB = 3;

    // task table entry layout: link selector, busy, saved nested flag, trap
    localparam int TNB_ENT_W = 19;
    localparam int TNB_ENT_BUSY = 16;
    localparam int TNB_ENT_NT = 17;
    localparam int TNB_ENT_TRAP = 18;

    // busy bit image inside the descriptor word at byte +4
    localparam int TNB_DESC_BYTE_OFS = 4;
    localparam int TNB_DESC_BUSY_BIT = 9;

    // register byte offsets
    localparam logic [7:0] TNB_OFS_STATUS = 8'h00;
    localparam logic [7:0] TNB_OFS_MASK = 8'h04;
    localparam logic [7:0] TNB_OFS_CPU = 8'h08;
    localparam logic [7:0] TNB_OFS_DBG = 8'h0c;
    localparam logic [7:0] TNB_OFS_TIDX = 8'h10;
    localparam logic [7:0] TNB_OFS_TDATA = 8'h14;
    localparam logic [7:0] TNB_OFS_DESC = 8'h18;

    // event bits of the status and mask registers
    localparam int TNB_EV_W = 3;
    localparam int TNB_EV_SWITCH = 0;
    localparam int TNB_EV_GP = 1;
    localparam int TNB_EV_DBG = 2;

    // fields of the cpu state and debug status registers
    localparam int TNB_CPU_NT = 16;
    localparam int TNB_CPU_TS = 17;
    localparam int TNB_DBG_BT = 15;

    // reset values
    localparam logic [TNB_EV_W-1:0] TNB_MASK_RST = 3'h0;
    localparam logic [TNB_SEL_W-1:0] TNB_SEL_RST = 16'h0000;

    // bus data phase steps: issue, capture, answer
    localparam logic [1:0] TNB_PH_ISSUE = 2'h0;
    localparam logic [1:0] TNB_PH_CAPT = 2'h1;
    localparam logic [1:0] TNB_PH_ANS = 2'h2;

    // how a task switch was started
    typedef enum logic [2:0] {
        TNB_JUMP,
        TNB_CALL,
        TNB_SWINT,
        TNB_HWINT,
        TNB_EXC,
        TNB_INTERRUPT_RETURN
    } tnb_kind_t;
endpackage

//--- verilog/tnb_task_mem.sv
// task table memory: one entry per task state segment
// single port, read data come out of a register one cycle after rd
`timescale 1ns/1ps
module tnb_task_mem #(
    parameter int AW = 6,
    parameter int DW = 19
) (
    input wire logic clk, // core clock
    input wire logic rd, // read strobe
    input wire logic we, // write strobe
    input wire logic [AW-1:0] addr, // entry index
    input wire logic [DW-1:0] wdata, // write data
    output logic [DW-1:0] rdata // registered read data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on the array: software loads entries before first use
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // read data held until the next read
    always_ff @(posedge clk) begin
        if (rd) begin
            rdata <= mem[addr];
        end
    end
endmodule

//--- verilog/tnb_irq.sv
// sticky event status with mask and one level interrupt
// a read of the status register clears it; a new event wins the clear
`timescale 1ns/1ps
module tnb_irq #(
    parameter int W = 3
) (
    input wire logic ref_clk, // core clock
    input wire logic rst, // async reset, active high
    input wire logic [W-1:0] ev, // event pulses
    input wire logic rd_clr, // status read clears
    input wire logic [W-1:0] mask, // enable per bit
    output logic [W-1:0] status_q, // sticky status
    output logic irq // level interrupt
);
    logic [W-1:0] status_d;

    // set beats clear so an event in the reading cycle survives
    always_comb begin
        status_d = (rd_clr ? '0 : status_q) | ev;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    assign irq = |(status_q & mask);
endmodule

//--- verilog/tnb_core.sv
// task nesting and busy control for the hardware task switch
// assumes an ahb-lite master and a pipeline giving one switch at a time
`timescale 1ns/1ps
module tnb_core (
    input wire logic ref_clk, // core clock, 40 MHz
    input wire logic rst, // async reset, active high
    // ahb-lite slave
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    // pipeline side
    input wire logic req_valid, // switch request
    input wire tnb_pkg::tnb_kind_t req_kind, // how it was started
    input wire logic [15:0] req_sel, // target selector
    output logic req_ready, // request taken when high
    input wire logic nt_wr, // flags write from pipeline
    input wire logic nt_wdata, // new nested flag value
    output logic done, // switch or return finished
    output logic gp_fault, // protection fault pulse
    output logic debug_trap, // debug trap pulse
    output logic [15:0] cur_sel, // current task selector
    output logic nested_task_flag, // current nested flag
    output logic task_switched_flag, // set on every switch
    output logic irq // level interrupt
);
    import tnb_pkg::*;

    typedef enum logic [2:0] {
        TNB_S_IDLE,
        TNB_S_GOT_CUR,
        TNB_S_RD_TGT,
        TNB_S_GOT_TGT,
        TNB_S_WR_OLD,
        TNB_S_WR_NEW
    } tnb_state_t;

    function automatic logic [TNB_IDX_W-1:0] sel_idx(
        input logic [TNB_SEL_W-1:0] s);
        sel_idx = s[TNB_SEL_IDX_LSB +: TNB_IDX_W];
    endfunction

    function automatic logic is_nesting(input tnb_kind_t k);
        is_nesting = (k == TNB_CALL) || (k == TNB_SWINT) ||
            (k == TNB_HWINT) || (k == TNB_EXC);
    endfunction

    tnb_state_t state_q;
    tnb_kind_t kind_q;
    logic [TNB_SEL_W-1:0] tgt_q;
    logic [TNB_ENT_W-1:0] cur_ent_q;
    logic [TNB_ENT_W-1:0] tgt_ent_q;
    logic [TNB_ENT_W-1:0] mem_rdata;
    logic [TNB_ENT_W-1:0] mem_wdata;
    logic [TNB_IDX_W-1:0] mem_addr;
    logic mem_rd;
    logic mem_we;
    logic [TNB_EV_W-1:0] ev;
    logic [TNB_EV_W-1:0] status_q;
    logic [TNB_EV_W-1:0] mask_q;
    logic bt_q;
    logic [TNB_IDX_W-1:0] tidx_q;
    logic dph_q;
    logic [1:0] ph_q;
    logic [7:0] dadr_q;
    logic dwr_q;
    logic take;
    logic bus_go;
    logic st_rd;
    logic [31:0] rd_mux;
    logic fault_d;
    logic trap_d;
    logic fin_d;

    // a switch starts only with the bus data phase out of the way
    assign req_ready = (state_q == TNB_S_IDLE) && !dph_q;
    assign take = req_valid && req_ready;

    // bus owns the table port while issuing, only when no switch runs
    assign bus_go = dph_q && (ph_q == TNB_PH_ISSUE) &&
        (state_q == TNB_S_IDLE);

    // switch sequence: read current, read target, check, write back
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= TNB_S_IDLE;
            kind_q <= TNB_JUMP;
            tgt_q <= TNB_SEL_RST;
        end else begin
            case (state_q)
                TNB_S_IDLE: begin
                    if (take && req_kind == TNB_INTERRUPT_RETURN &&
                            !nested_task_flag) begin
                        state_q <= TNB_S_IDLE;
                    end else if (take) begin
                        state_q <= TNB_S_GOT_CUR;
                        kind_q <= req_kind;
                        tgt_q <= req_sel;
                    end
                end
                TNB_S_GOT_CUR: begin
                    if (kind_q == TNB_INTERRUPT_RETURN) begin
                        tgt_q <= mem_rdata[TNB_SEL_W-1:0];
                    end
                    state_q <= TNB_S_RD_TGT;
                end
                TNB_S_RD_TGT: begin
                    state_q <= TNB_S_GOT_TGT;
                end
                TNB_S_GOT_TGT: begin
                    if (kind_q != TNB_INTERRUPT_RETURN && mem_rdata[TNB_ENT_BUSY]) begin
                        state_q <= TNB_S_IDLE;
                    end else begin
                        state_q <= TNB_S_WR_OLD;
                    end
                end
                TNB_S_WR_OLD: begin
                    if (kind_q == TNB_INTERRUPT_RETURN) begin
                        state_q <= TNB_S_IDLE;
                    end else begin
                        state_q <= TNB_S_WR_NEW;
                    end
                end
                TNB_S_WR_NEW: begin
                    state_q <= TNB_S_IDLE;
                end
                default: begin
                    state_q <= TNB_S_IDLE;
                end
            endcase
        end
    end

    // latch the two entries as they come out of the table
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_ent_q <= '0;
            tgt_ent_q <= '0;
        end else begin
            if (state_q == TNB_S_GOT_CUR) begin
                cur_ent_q <= mem_rdata;
            end
            if (state_q == TNB_S_GOT_TGT) begin
                tgt_ent_q <= mem_rdata;
            end
        end
    end

    // table port: switch sequence first, bus only when idle
    always_comb begin
        mem_rd = 1'b0;
        mem_we = 1'b0;
        mem_addr = tidx_q;
        mem_wdata = hwdata[TNB_ENT_W-1:0];
        case (state_q)
            TNB_S_IDLE: begin
                if (take) begin
                    mem_rd = 1'b1;
                    mem_addr = sel_idx(cur_sel);
                end else if (bus_go) begin
                    mem_rd = !dwr_q;
                    mem_we = dwr_q && (dadr_q == TNB_OFS_TDATA);
                end
            end
            TNB_S_RD_TGT: begin
                mem_rd = 1'b1;
                mem_addr = sel_idx(tgt_q);
            end
            TNB_S_WR_OLD: begin
                mem_we = 1'b1;
                mem_addr = sel_idx(cur_sel);
                mem_wdata = cur_ent_q;
                mem_wdata[TNB_ENT_NT] = nested_task_flag;
                if (kind_q == TNB_INTERRUPT_RETURN) begin
                    mem_wdata[TNB_ENT_NT] = 1'b0;
                end
                mem_wdata[TNB_ENT_BUSY] = is_nesting(kind_q);
            end
            TNB_S_WR_NEW: begin
                mem_we = 1'b1;
                mem_addr = sel_idx(tgt_q);
                mem_wdata = tgt_ent_q;
                mem_wdata[TNB_ENT_BUSY] = 1'b1;
                if (is_nesting(kind_q)) begin
                    mem_wdata[TNB_ENT_NT] = 1'b1;
                    mem_wdata[TNB_SEL_W-1:0] = cur_sel;
                end
            end
            default: begin
                mem_rd = 1'b0;
            end
        endcase
    end

    tnb_task_mem #(
        .AW(TNB_IDX_W),
        .DW(TNB_ENT_W)
    ) u_mem (
        .clk(ref_clk),
        .rd(mem_rd),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // outcome of the check, known in the cycle that decides it
    always_comb begin
        fault_d = (state_q == TNB_S_GOT_TGT) && kind_q != TNB_INTERRUPT_RETURN &&
            mem_rdata[TNB_ENT_BUSY];
        fin_d = (state_q == TNB_S_WR_OLD && kind_q == TNB_INTERRUPT_RETURN) ||
            (state_q == TNB_S_WR_NEW);
        trap_d = fin_d && tgt_ent_q[TNB_ENT_TRAP];
    end

    // event pulses toward the pipeline, one cycle each
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            gp_fault <= 1'b0;
            debug_trap <= 1'b0;
        end else begin
            done <= fin_d || (take && req_kind == TNB_INTERRUPT_RETURN &&
                !nested_task_flag);
            gp_fault <= fault_d;
            debug_trap <= trap_d;
        end
    end

    // current task, nested flag and task switched flag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_sel <= TNB_SEL_RST;
            nested_task_flag <= 1'b0;
            task_switched_flag <= 1'b0;
        end else begin
            if (fin_d) begin
                cur_sel <= tgt_q;
                nested_task_flag <= is_nesting(kind_q) ? 1'b1 :
                    tgt_ent_q[TNB_ENT_NT];
                task_switched_flag <= 1'b1;
            end else if (nt_wr) begin
                nested_task_flag <= nt_wdata;
            end else if (bus_go && dwr_q && dadr_q == TNB_OFS_CPU) begin
                cur_sel <= hwdata[TNB_SEL_W-1:0];
                nested_task_flag <= hwdata[TNB_CPU_NT];
                task_switched_flag <= hwdata[TNB_CPU_TS];
            end
        end
    end

    // debug status bit: hardware set wins a software clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bt_q <= 1'b0;
        end else if (trap_d) begin
            bt_q <= 1'b1;
        end else if (bus_go && dwr_q && dadr_q == TNB_OFS_DBG) begin
            bt_q <= hwdata[TNB_DBG_BT];
        end
    end

    // software writable mask and table index
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_q <= TNB_MASK_RST;
            tidx_q <= '0;
        end else if (bus_go && dwr_q) begin
            if (dadr_q == TNB_OFS_MASK) begin
                mask_q <= hwdata[TNB_EV_W-1:0];
            end
            if (dadr_q == TNB_OFS_TIDX) begin
                tidx_q <= hwdata[TNB_IDX_W-1:0];
            end
        end
    end

    // sticky events and the interrupt line
    always_comb begin
        ev = '0;
        ev[TNB_EV_SWITCH] = fin_d;
        ev[TNB_EV_GP] = fault_d;
        ev[TNB_EV_DBG] = trap_d;
    end

    // clear lands with the capture edge, so the read returns the old bits
    assign st_rd = dph_q && ph_q == TNB_PH_CAPT && !dwr_q &&
        dadr_q == TNB_OFS_STATUS;

    tnb_irq #(
        .W(TNB_EV_W)
    ) u_irq (
        .ref_clk(ref_clk),
        .rst(rst),
        .ev(ev),
        .rd_clr(st_rd),
        .mask(mask_q),
        .status_q(status_q),
        .irq(irq)
    );

    // data phase: issue (waits for idle), capture, answer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dph_q <= 1'b0;
            ph_q <= TNB_PH_ISSUE;
            dadr_q <= 8'h00;
            dwr_q <= 1'b0;
        end else if (!dph_q || ph_q == TNB_PH_ANS) begin
            // the next address phase may arrive in the answer cycle
            dph_q <= hsel && htrans[1] && hready;
            ph_q <= TNB_PH_ISSUE;
            if (hsel && htrans[1] && hready) begin
                dadr_q <= haddr[7:0];
                dwr_q <= hwrite;
            end
        end else if (ph_q == TNB_PH_ISSUE) begin
            if (bus_go) begin
                ph_q <= TNB_PH_CAPT;
            end
        end else if (ph_q == TNB_PH_CAPT) begin
            ph_q <= TNB_PH_ANS;
        end
    end

    // read mux; status sampled before its clear lands
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (dadr_q)
            TNB_OFS_STATUS: rd_mux[TNB_EV_W-1:0] = status_q;
            TNB_OFS_MASK: rd_mux[TNB_EV_W-1:0] = mask_q;
            TNB_OFS_CPU: begin
                rd_mux[TNB_SEL_W-1:0] = cur_sel;
                rd_mux[TNB_CPU_NT] = nested_task_flag;
                rd_mux[TNB_CPU_TS] = task_switched_flag;
            end
            TNB_OFS_DBG: rd_mux[TNB_DBG_BT] = bt_q;
            TNB_OFS_TIDX: rd_mux[TNB_IDX_W-1:0] = tidx_q;
            TNB_OFS_TDATA: rd_mux[TNB_ENT_W-1:0] = mem_rdata;
            TNB_OFS_DESC: rd_mux[TNB_DESC_BUSY_BIT] =
                mem_rdata[TNB_ENT_BUSY];
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data registered in the capture step
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (dph_q && ph_q == TNB_PH_CAPT && !dwr_q) begin
            hrdata <= rd_mux;
        end
    end

    assign hreadyout = !dph_q || (ph_q == TNB_PH_ANS);
    assign hresp = 1'b0;
endmodule

//--- tb/tnb_core_chk.sv
// checker for the task nesting and busy control block
// bound to tnb_core, sees its ports only
`timescale 1ns/1ps
module tnb_core_chk
    import tnb_pkg::*;
(
    input wire logic ref_clk, // core clock
    input wire logic rst, // async reset
    input wire logic hsel, // slave select
    input wire logic [1:0] htrans, // transfer type
    input wire logic hready, // bus ready
    input wire logic hreadyout, // slave ready
    input wire logic req_valid, // switch request
    input wire tnb_pkg::tnb_kind_t req_kind, // initiator
    input wire logic req_ready, // request taken
    input wire logic nt_wr, // flag write
    input wire logic nt_wdata, // flag value
    input wire logic done, // finished pulse
    input wire logic gp_fault, // fault pulse
    input wire logic debug_trap, // trap pulse
    input wire logic nested_task_flag, // nested flag
    input wire logic task_switched_flag // switched flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic take;
    logic nest_kind;
    // decode the take once; the fault path always answers at +4
    assign take = req_valid && req_ready;
    assign nest_kind = req_kind inside {TNB_CALL, TNB_SWINT, TNB_HWINT,
        TNB_EXC};
    jump_done_a: assert property (
        take && req_kind == TNB_JUMP |-> (##4 gp_fault) or (##6 done))
        else $error("jump switch did not end in time");
    call_nest_a: assert property (
        take && nest_kind |->
        (##4 gp_fault) or (##6 (done && nested_task_flag)))
        else $error("nesting switch left nested flag clear");
    ts_set_a: assert property (
        take && req_kind != TNB_INTERRUPT_RETURN |->
        (##4 gp_fault) or (##6 task_switched_flag))
        else $error("task switched flag not set");
    interrupt_return_switch_a: assert property (
        take && req_kind == TNB_INTERRUPT_RETURN && nested_task_flag |->
        ##4 !done ##1 done)
        else $error("nested return did not switch");
    interrupt_return_plain_a: assert property (
        take && req_kind == TNB_INTERRUPT_RETURN && !nested_task_flag |=> done)
        else $error("plain return not finished");
    trap_done_a: assert property (
        debug_trap |-> done && !gp_fault)
        else $error("trap without finished switch");
    gp_no_done_a: assert property (
        gp_fault |-> !done ##1 !done)
        else $error("fault followed by a switch");
    nt_any_a: assert property (
        nt_wr && req_ready && !req_valid |=>
        nested_task_flag == $past(nt_wdata))
        else $error("nested flag write lost");
    bus_wait_a: assert property (
        hsel && htrans[1] && hready |=> !hreadyout [*2])
        else $error("bus answered too early");
endmodule
bind tnb_core tnb_core_chk tnb_core_chk_i (.ref_clk, .rst, .hsel, .htrans,
    .hready, .hreadyout, .req_valid, .req_kind, .req_ready, .nt_wr,
    .nt_wdata, .done, .gp_fault, .debug_trap, .nested_task_flag,
    .task_switched_flag);

//--- tb/tnb_pipe_model.sv
// model of the pipeline that starts task switches and writes the flag
// driven by tasks called from the bench, one request at a time
`timescale 1ns/1ps
module tnb_pipe_model
    import tnb_pkg::*;
(
    input wire logic ref_clk, // core clock
    input wire logic req_ready, // block takes request
    output logic req_valid, // switch request
    output tnb_pkg::tnb_kind_t req_kind, // initiator
    output logic [15:0] req_sel, // target selector
    output logic nt_wr, // flag write strobe
    output logic nt_wdata // flag value
);
    // idle values at time zero
    initial begin
        req_valid = 1'b0;
        req_kind = TNB_JUMP;
        req_sel = 16'h0000;
        nt_wr = 1'b0;
        nt_wdata = 1'b0;
    end

    // request held until req_ready is seen at an edge; start may lag
    task automatic issue(input tnb_kind_t k, input logic [15:0] s,
            input int slow, output logic ok);
        int n;
        ok = 1'b0;
        repeat (slow) @(posedge ref_clk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_sel <= s;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge ref_clk);
            ok = req_ready;
        end
        req_valid <= 1'b0;
        // released selector shows the inverted selector, not the old value
        req_sel <= ~s;
    endtask

    task automatic set_nt(input logic v);
        nt_wr <= 1'b1;
        nt_wdata <= v;
        @(posedge ref_clk);
        nt_wr <= 1'b0;
        nt_wdata <= ~v;
    endtask
endmodule

//--- tb/tb_top.sv
// top bench for the task nesting and busy control block
// drives the register bus and the pipeline model; results via a queue
`timescale 1ns/1ps
module tb_top
    import tnb_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, ok, rd_pend = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, req_valid, req_ready, nt_wr, nt_wdata, done;
    logic gp_fault, debug_trap, nested_task_flag, task_switched_flag, irq;
    logic [15:0] req_sel, cur_sel, sel;
    tnb_kind_t req_kind;
    logic [31:0] exp_q[$];
    int fail_count = 0, n_tests = 0, seed = 32'h507eebda, idx;

    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    tnb_core tnb_core_i (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .req_valid, .req_kind, .req_sel, .req_ready, .nt_wr, .nt_wdata,
        .done, .gp_fault, .debug_trap, .cur_sel, .nested_task_flag,
        .task_switched_flag, .irq);
    tnb_pipe_model tnb_pipe_model_i (.ref_clk, .req_ready, .req_valid,
        .req_kind, .req_sel, .nt_wr, .nt_wdata);

    task automatic check(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic summarize;
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic timeout;
        fail_count++;
        $display("mismatch wait exp answer got none");
        summarize();
    endtask

    // single word transfer; each phase ends on an edge with hready high
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (!hreadyout && n < 40);
            if (!hreadyout) timeout();
            if (p == 0) begin
                // data phase: address released, write data on
                hsel <= 1'b0;
                htrans <= 2'b00;
                hwdata <= d;
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, $random(seed));
    endtask

    task automatic drain;
        int n;
        for (n = 0; n < 40 && exp_q.size() > 0; n++) @(posedge ref_clk);
        if (exp_q.size() > 0) timeout();
    endtask

    // e is {fault, done, trap, nested, selector}
    task automatic sw(input tnb_kind_t k, input logic [15:0] s,
            input logic [19:0] e);
        exp_q.push_back({12'h000, e});
        tnb_pipe_model_i.issue(k, s, $random(seed) & 3, ok);
        if (!ok) timeout();
        drain();
    endtask

    task automatic take_note(input string nm, input logic [31:0] g);
        if (exp_q.size() == 0) begin
            check(nm, 32'hdead_0000, g);
        end else begin
            check(nm, exp_q.pop_front(), g);
        end
    endtask

    // watcher: every bus read answer or switch result takes the oldest note
    always @(posedge ref_clk) begin
        if (rd_pend && hreadyout) begin
            rd_pend = 1'b0;
            take_note("read", hrdata);
            check("hresp", 32'h0, {31'h0, hresp});
        end
        if (hsel && htrans[1] && hreadyout && !hwrite) begin
            rd_pend = 1'b1;
        end
        if (done || gp_fault) begin
            take_note("switch", {12'h000, gp_fault, done, debug_trap,
                nested_task_flag, cur_sel});
        end
    end

    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 64; i++) begin
            wr(TNB_OFS_TIDX, i);
            wr(TNB_OFS_TDATA,
                {13'h0000, i == 5, 1'b0, i == 0, 16'h0000});
        end
        $display("test table load done");
        sw(TNB_JUMP, 16'h0008, 20'h4_0008);
        check("irq", 32'h0, {31'h0, irq});
        wr(TNB_OFS_MASK, 32'h0000_0001);
        check("irq", 32'h1, {31'h0, irq});
        rd(TNB_OFS_STATUS, 32'h0000_0001);
        check("irq", 32'h0, {31'h0, irq});
        rd(TNB_OFS_DESC, 32'h0000_0000);
        wr(TNB_OFS_TIDX, 1);
        rd(TNB_OFS_DESC, 32'h0000_0200);
        rd(TNB_OFS_TDATA, 32'h0001_0000);
        sw(TNB_JUMP, 16'h0008, 20'h8_0008);
        $display("test jump done");
        wr(TNB_OFS_CPU, 32'h0000_0008);
        sw(TNB_CALL, 16'h0010, 20'h5_0010);
        rd(TNB_OFS_CPU, 32'h0003_0010);
        rd(TNB_OFS_TDATA, 32'h0001_0000);
        wr(TNB_OFS_TIDX, 2);
        rd(TNB_OFS_TDATA, 32'h0003_0008);
        for (int k = 0; k < 3; k++) begin
            sel = 16'h0018 + 16'(k * 8);
            sw(tnb_kind_t'(k + 2), sel, {2'b01, k == 2, 1'b1, sel});
        end
        rd(TNB_OFS_DBG, 32'h0000_8000);
        wr(TNB_OFS_DBG, 32'h0000_0000);
        rd(TNB_OFS_DBG, 32'h0000_0000);
        sw(TNB_CALL, 16'h0010, 20'h9_0028);
        $display("test call chain done");
        sw(TNB_INTERRUPT_RETURN, 16'($random(seed)), 20'h5_0020);
        wr(TNB_OFS_TIDX, 5);
        rd(TNB_OFS_TDATA, 32'h0004_0020);
        wr(TNB_OFS_TIDX, 4);
        rd(TNB_OFS_TDATA, 32'h0003_0018);
        tnb_pipe_model_i.set_nt(1'b0);
        sw(TNB_INTERRUPT_RETURN, 16'($random(seed)), 20'h4_0020);
        tnb_pipe_model_i.set_nt(1'b1);
        sw(TNB_INTERRUPT_RETURN, 16'($random(seed)), 20'h5_0018);
        $display("test return done");
        idx = 8 + ($random(seed) & 31);
        sel = 16'(idx * 8);
        sw(TNB_JUMP, sel, {4'h4, sel});
        wr(8'h1c, $random(seed));
        rd(8'h1c, 32'h0000_0000);
        rd(TNB_OFS_STATUS, 32'h0000_0007);
        check("irq", 32'h0, {31'h0, irq});
        $display("test misc done");
        summarize();
    end
endmodule
